// *** hdl/slmrc_frame_map.sv ***
// reorders lane slots into sample order for the programmed interleave step
`timescale 1ns/100ps
module slmrc_frame_map
  import slmrc_pkg::*;
(
  input  slmrc_pkg::slmrc_frame_s slotIn,
  input  wire logic [4:0]   samplesPerFrame,
  input  wire logic [4:0]   interleaveStep,
  output slmrc_pkg::slmrc_frame_s sampleOut
);
  import slmrc_pkg::*;

  // sample index carried by slot p: walk 0, step, 2*step..., each pass one higher
  function automatic logic [4:0] slotSample(input logic [4:0] p, input logic [4:0] s, input logic [4:0] si);
    logic [5:0] idx;
    logic [5:0] cnt;
    logic [4:0] res;
    res = p;
    cnt = 6'h00;
    for (int r = 0; r < SLOTS; r++)
    begin
      for (int q = 0; q < SLOTS; q++)
      begin
        idx = 6'(r + q * int'(si));
        if (6'(r) < {1'b0, si} && idx < {1'b0, s})
        begin
          if (cnt == {1'b0, p})
            res = idx[4:0];
          cnt = cnt + 6'h01;
        end
      end
    end
    return res;
  endfunction

  // a step of one or less keeps the linear mapping
  wire linearMap = interleaveStep <= 5'h01;

  always_comb
  begin
    sampleOut = '0;
    for (int p = 0; p < SLOTS; p++)
    begin
      if (linearMap || 5'(p) >= samplesPerFrame)
        sampleOut.smp[p] = slotIn.smp[p];
      else
        sampleOut.smp[slotSample(5'(p), samplesPerFrame, interleaveStep)] = slotIn.smp[p];
    end
  end
endmodule

// *** hdl/slmrc_link_ctrl.sv ***
// receive-side link control: mode decode, link reset, sync, buffer release, alarm and data-path mode
//
// Function
// - subclass 0 runs without SYSREF; multiframe counter free-runs from arbitrary phase
// - subclass 0 releases elastic buffer just after the last lane starts writing
// - SYNC requests code group sync and lane alignment in every subclass
// - gearbox fault bit on any active lane resets the whole link layer
// - elastic buffer overflow on any active lane resets the whole link layer
// - link-down alarm or watchdog expiry alarm resets the whole link layer
// - SYSREF realign event resets the whole link layer
// - alarm output is active when any unmasked system alarm flag is set
// - upconverter mode sums all upconverter outputs before conversion
// - synthesis mode uses NCO tones, interpolation and complex mixing off
// - synthesis mode keeps the serial receive interface disabled
// - synthesis mode scales each channel tone by its own tone level
// - synthesis mode ignores mode number and interpolation, drops SYSREF period checks
// - lanes per stream, max lanes and max streams come from mode number
// - dual-edge 1x gives ratio one half and two samples per clock
// - otherwise ratio equals interpolation factor 1 to 256; dual-edge 2x no effect
// - active lanes shrink to ceiling of streams times max lanes over max streams
// - interleave step 1 maps linearly, larger steps stride and restart one higher
// - multiframe length must be a multiple of 64 characters, 32 if K=32,F=1
`timescale 1ns/100ps
module slmrc_link_ctrl
  import slmrc_pkg::*;
(
  input  wire logic                     sys_clk,
  input  wire logic                     srst,
  input  wire logic                     clkEn,
  input  slmrc_pkg::slmrc_cfg_s         cfg,
  input  wire logic                     sysref,
  input  slmrc_pkg::slmrc_lane_fault_s  laneFault,
  input  wire logic                     linkDownAlarm,
  input  wire logic                     timerExpiredAlarm,
  input  wire logic                     realignEvent,
  input  wire logic                     cgsDone,
  input  wire logic [slmrc_pkg::LANES-1:0] laneWriteStart,
  input  wire logic [slmrc_pkg::ALM_W-1:0] systemAlarmFlags,
  input  wire logic [slmrc_pkg::ALM_W-1:0] alarmMask,
  input  slmrc_pkg::slmrc_frame_s       frameIn,
  input  wire logic                     frameInValid,
  output logic                          frameInReady,
  output slmrc_pkg::slmrc_frame_s       frameOut,
  output logic                          frameOutValid,
  input  wire logic                     frameOutReady,
  input  slmrc_pkg::slmrc_chan_t        ducOut,
  input  slmrc_pkg::slmrc_chan_t        ncoTone,
  input  slmrc_pkg::slmrc_chan_t        toneLevel,
  output logic                          syncN,
  output logic                          rxEnable,
  output logic                          linkResetPulse,
  output logic                          bufferRelease,
  output logic                          lmfcEdge,
  output logic [slmrc_pkg::LANES-1:0]   activeLaneMask,
  output slmrc_pkg::slmrc_param_s       linkParams,
  output logic                          interpFilterEnable,
  output logic                          complexMixEnable,
  output logic                          sysrefPeriodCheck,
  output logic                          alarmOut,
  output logic signed [17:0]            convSample
);
  import slmrc_pkg::*;

  slmrc_state_e      state;
  slmrc_state_e      next_state;
  logic [LMFC_W-1:0] lmfcCount;
  logic [LANES-1:0]  arrived;
  logic [LANES-1:0]  next_arrived;
  logic              allArrivedD;
  slmrc_mode_s       modeSel;
  slmrc_param_s      next_params;
  slmrc_frame_s      mappedFrame;
  logic              bufInReady;
  logic signed [17:0] next_sum;

  // mode decode; an unknown number selects nothing so no lanes are active
  wire        modeKnown = cfg.linkModeNumber <= MODE_MAX;
  wire [1:0]  modeIdx   = modeKnown ? cfg.linkModeNumber[1:0] : 2'h0;
  assign modeSel = modeKnown ? MODE_TABLE[modeIdx] : '0;

  // programmed stream count replaces the mode maximum when it is in range
  wire [7:0]  maxStreams  = {3'h0, modeSel.maxStreamCount};
  wire        streamsOk   = cfg.streamCount != 8'h00 && cfg.streamCount <= maxStreams;
  wire [7:0]  streamsUsed = streamsOk ? cfg.streamCount : maxStreams;
  wire [12:0] laneProd    = 13'(streamsUsed * modeSel.maxLaneCount);
  wire [12:0] divisor     = {8'h00, modeSel.maxStreamCount};
  wire [12:0] laneCeil    = (divisor == 13'h0000) ? 13'h0000
                          : 13'((laneProd + divisor - 13'h0001) / divisor);
  wire [4:0]  activeLanes = laneCeil[4:0];
  wire [16:0] laneMaskW   = 17'((17'h00001 << activeLanes) - 17'h00001);
  assign activeLaneMask = laneMaskW[LANES-1:0];

  // ratio kept in halves so the dual-edge value of one half stays exact
  wire [8:0] interpUsed = (cfg.interpolationFactor < INTERP_MIN) ? INTERP_MIN
                        : (cfg.interpolationFactor > INTERP_MAX) ? INTERP_MAX
                        : cfg.interpolationFactor;
  wire [9:0] ratioNorm  = cfg.dualEdge1x ? RATIO_X2_DUAL_EDGE_1X : {interpUsed, 1'b0};
  wire [9:0] ratioUsed  = cfg.ddsMode ? {INTERP_MIN, 1'b0} : ratioNorm;

  // multiframe length check, depth halves for the one short case
  wire [8:0]  framesK   = {1'b0, cfg.framesPerMultiframeMinusOne} + 9'h001;
  wire [15:0] mfChars   = 16'(framesK * modeSel.octetsPerFrame);
  wire        shortBuf  = framesK == SHORT_K && modeSel.octetsPerFrame == SHORT_F;
  wire [15:0] mfDepth   = shortBuf ? EB_DEPTH_SHORT : EB_DEPTH;
  wire        mfLegal   = cfg.use64b66b || (mfChars != 16'h0000 && (mfChars & (mfDepth - 16'h0001)) == 16'h0000);

  always_comb
  begin
    next_params                 = '0;
    next_params.lanesPerStream  = modeSel.lanesPerStream;
    next_params.maxLaneCount    = modeSel.maxLaneCount;
    next_params.maxStreamCount  = modeSel.maxStreamCount;
    next_params.activeLanes     = activeLanes;
    next_params.ratioX2         = ratioUsed;
    next_params.samplesPerClock = cfg.dualEdge1x && !cfg.ddsMode ? SMP_PER_CLK_2 : SMP_PER_CLK_1;
    next_params.multiframeLegal = mfLegal;
    next_params.modeInvalid     = !modeKnown && !cfg.ddsMode;
  end

  // link reset causes; only the two lane faults are gated by the lanes of the active link
  wire gearboxHit  = |(laneFault.gearboxFault & activeLaneMask);
  wire overflowHit = |(laneFault.bufferOverflowError & activeLaneMask);
  wire alarmHit    = linkDownAlarm || timerExpiredAlarm;
  wire resetCause  = gearboxHit || overflowHit || alarmHit || realignEvent;
  wire linkOn      = !cfg.ddsMode;

  // lane arrival tracking; a start during lane alignment is kept even in a link reset pulse cycle
  wire inAlign    = state == LANE_ALIGN;
  wire clrArrival = state != LANE_ALIGN || linkResetPulse;
  assign next_arrived = (clrArrival ? '0 : arrived) | (laneWriteStart & activeLaneMask & {LANES{inAlign}});
  wire allArrived = activeLaneMask != '0 && (arrived & activeLaneMask) == activeLaneMask;

  // subclass 0 releases on the first cycle all lanes are seen, subclass 1 waits for the delay
  wire releaseSc0 = allArrived && !allArrivedD;
  wire releaseSc1 = allArrived && lmfcCount == cfg.bufferReleaseDelay;
  assign bufferRelease = clkEn && inAlign && !linkResetPulse && (cfg.subclassZero ? releaseSc0 : releaseSc1);

  // local multiframe reference; only subclass 1 lets SYSREF restart it
  wire sysrefAlign = sysref && !cfg.subclassZero;
  assign lmfcEdge = lmfcCount == '0;

  // link state sequence
  always_comb
  begin
    next_state = state;
    unique case (state)
      LINK_OFF:   next_state = SYNC_REQ;
      SYNC_REQ:   if (cgsDone && mfLegal && modeKnown) next_state = LANE_ALIGN;
      LANE_ALIGN: if (bufferRelease) next_state = LINK_DATA;
      LINK_DATA:  next_state = LINK_DATA;
    endcase
    if (linkResetPulse)
      next_state = SYNC_REQ;
    if (!linkOn)
      next_state = LINK_OFF;
  end

  // SYNC held low only while asking for code group sync
  assign syncN    = state != SYNC_REQ;
  assign rxEnable = state != LINK_OFF;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      state <= LINK_OFF;
    else if (clkEn)
      state <= next_state;
  end

  // reset pulse is one cycle late so a burst of causes restarts the link once per cycle
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      linkResetPulse <= 1'b0;
    else if (clkEn)
      linkResetPulse <= resetCause && linkOn;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      arrived     <= '0;
      allArrivedD <= 1'b0;
    end
    else if (clkEn)
    begin
      arrived     <= next_arrived;
      allArrivedD <= allArrived;
    end
  end

  // free-running from reset gives an arbitrary phase in subclass 0
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      lmfcCount <= '0;
    else if (clkEn)
      lmfcCount <= sysrefAlign ? '0 : lmfcCount + 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      linkParams <= '0;
    else if (clkEn)
      linkParams <= next_params;
  end

  // alarm pin registered so a glitch on the flags never reaches the pin
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      alarmOut <= 1'b0;
    else if (clkEn)
      alarmOut <= |(systemAlarmFlags & ~alarmMask);
  end

  // frame path: only live in data state, flushed by any link reset
  slmrc_frame_map u_map (
    .slotIn          (frameIn),
    .samplesPerFrame (modeSel.samplesPerFrame),
    .interleaveStep  (cfg.sampleInterleaveStep),
    .sampleOut       (mappedFrame)
  );

  wire dataOpen = state == LINK_DATA && linkOn;
  // ready is withheld while frozen so the sender never counts a word that was not taken
  assign frameInReady = bufInReady && dataOpen && clkEn;

  slmrc_skid_buf u_buf (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .clkEn    (clkEn),
    .flush    (linkResetPulse || !linkOn),
    .inData   (mappedFrame),
    .inValid  (frameInValid && dataOpen),
    .inReady  (bufInReady),
    .outData  (frameOut),
    .outValid (frameOutValid),
    .outReady (frameOutReady)
  );

  // upconverter control; synthesis mode needs neither filters nor complex mixing
  assign interpFilterEnable = linkOn;
  assign complexMixEnable   = linkOn;
  assign sysrefPeriodCheck  = linkOn;

  // tone scaled by an unsigned level, full scale just under one
  function automatic logic signed [15:0] scaleTone(input logic [15:0] tone, input logic [15:0] level);
    logic signed [32:0] prod;
    prod = $signed({{17{tone[15]}}, tone}) * $signed({17'h00000, level});
    return prod[31:16];
  endfunction

  // channel sum; the 18-bit total cannot overflow with four 16-bit terms
  always_comb
  begin
    next_sum = '0;
    for (int c = 0; c < CHANS; c++)
    begin
      if (cfg.ddsMode)
        next_sum = next_sum + 18'(scaleTone(ncoTone[c], toneLevel[c]));
      else
        next_sum = next_sum + 18'($signed(ducOut[c]));
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      convSample <= '0;
    else if (clkEn)
      convSample <= next_sum;
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_last_lane;
    clkEn && cfg.subclassZero && inAlign && !linkResetPulse && !allArrived && linkOn
    ##1 clkEn && cfg.subclassZero && allArrived && inAlign && !linkResetPulse;
  endsequence

  sequence s_reset_then_req;
    clkEn && linkResetPulse && linkOn ##1 !syncN;
  endsequence

  a_sc0_free_count: assert property (clkEn && cfg.subclassZero |=> lmfcCount == $past(lmfcCount) + 1'b1)
    else $error("multiframe counter did not free-run in subclass 0");
  a_sc0_auto_release: assert property (s_last_lane |-> bufferRelease)
    else $error("buffer not released after last lane arrived");
  a_sync_needs_cgs: assert property (clkEn && state == SYNC_REQ && !cgsDone && linkOn |=> !syncN)
    else $error("SYNC released without code group sync");
  a_gearbox_reset: assert property (clkEn && linkOn && |(laneFault.gearboxFault & activeLaneMask) |=> linkResetPulse)
    else $error("gearbox fault did not reset link");
  a_overflow_reset: assert property (clkEn && linkOn && |(laneFault.bufferOverflowError & activeLaneMask) |=> linkResetPulse)
    else $error("buffer overflow did not reset link");
  a_alarm_reset: assert property (clkEn && linkOn && (linkDownAlarm || timerExpiredAlarm) |=> linkResetPulse)
    else $error("link alarm did not reset link");
  a_realign_reset: assert property (clkEn && linkOn && realignEvent |=> linkResetPulse ##1 !syncN || !linkOn)
    else $error("realign event did not restart link");
  a_alarm_pin: assert property (clkEn |=> alarmOut == |($past(systemAlarmFlags) & ~$past(alarmMask)))
    else $error("alarm pin disagrees with unmasked flags");
  a_resync_after: assert property (clkEn && linkResetPulse && linkOn |-> s_reset_then_req)
    else $error("no sync request after link reset");
  a_dds_rx_off: assert property (clkEn && cfg.ddsMode [*2] |-> !rxEnable && !frameInReady && !interpFilterEnable)
    else $error("receive interface active in synthesis mode");
  a_dual_edge_1x_ratio: assert property (clkEn && cfg.dualEdge1x && !cfg.ddsMode |=> linkParams.ratioX2 == RATIO_X2_DUAL_EDGE_1X
                                  && linkParams.samplesPerClock == SMP_PER_CLK_2)
    else $error("dual-edge 1x ratio wrong");
  a_interp_ratio: assert property (clkEn && !cfg.dualEdge1x && !cfg.ddsMode && cfg.interpolationFactor == 9'h008
                                   |=> linkParams.ratioX2 == 10'h010)
    else $error("ratio does not follow interpolation factor");
  a_mf_legal: assert property (clkEn && !cfg.use64b66b && mfChars[4:0] != 5'h00 |=> !linkParams.multiframeLegal)
    else $error("illegal multiframe length accepted");
endmodule

// *** hdl/slmrc_pkg.sv ***
// shared constants, carrier types and link mode table for the serial link control block
package slmrc_pkg;
  localparam int LANES  = 16;
  localparam int CHANS  = 4;
  localparam int SLOTS  = 16;
  localparam int SMP_W  = 16;
  localparam int ALM_W  = 8;
  localparam int LMFC_W = 6;

  // interpolation factor limits
  localparam logic [8:0]  INTERP_MIN     = 9'h001;
  localparam logic [8:0]  INTERP_MAX     = 9'h100;
  // elastic buffer depth in characters, and the short case
  localparam logic [15:0] EB_DEPTH       = 16'h0040;
  localparam logic [15:0] EB_DEPTH_SHORT = 16'h0020;
  localparam logic [8:0]  SHORT_K        = 9'h020;
  localparam logic [7:0]  SHORT_F        = 8'h01;
  localparam logic [9:0]  RATIO_X2_DUAL_EDGE_1X = 10'h001;
  localparam logic [1:0]  SMP_PER_CLK_1  = 2'h1;
  localparam logic [1:0]  SMP_PER_CLK_2  = 2'h2;
  localparam logic [4:0]  MODE_MAX       = 5'h02;

  typedef enum logic [1:0] {LINK_OFF, SYNC_REQ, LANE_ALIGN, LINK_DATA} slmrc_state_e;

  typedef struct packed {
    logic [4:0] lanesPerStream;
    logic [4:0] maxLaneCount;
    logic [4:0] maxStreamCount;
    logic [7:0] octetsPerFrame;
    logic [4:0] samplesPerFrame;
  } slmrc_mode_s;

  // supported modes indexed by the link mode number
  localparam slmrc_mode_s MODE_TABLE [3] = '{
    '{5'h10, 5'h10, 5'h01, 8'h02, 5'h10},
    '{5'h08, 5'h10, 5'h02, 8'h02, 5'h08},
    '{5'h04, 5'h10, 5'h04, 8'h02, 5'h04}
  };

  typedef struct packed {
    logic                subclassZero;
    logic                ddsMode;
    logic                use64b66b;
    logic [4:0]          linkModeNumber;
    logic [8:0]          interpolationFactor;
    logic                dualEdge1x;
    logic                dualEdge2x;
    logic [7:0]          streamCount;
    logic [4:0]          sampleInterleaveStep;
    logic [7:0]          framesPerMultiframeMinusOne;
    logic [LMFC_W-1:0]   bufferReleaseDelay;
  } slmrc_cfg_s;

  typedef struct packed {
    logic [LANES-1:0] gearboxFault;
    logic [LANES-1:0] bufferOverflowError;
  } slmrc_lane_fault_s;

  typedef struct packed {
    logic [4:0] lanesPerStream;
    logic [4:0] maxLaneCount;
    logic [4:0] maxStreamCount;
    logic [4:0] activeLanes;
    logic [9:0] ratioX2;
    logic [1:0] samplesPerClock;
    logic       multiframeLegal;
    logic       modeInvalid;
  } slmrc_param_s;

  typedef struct packed {
    logic [SLOTS-1:0][SMP_W-1:0] smp;
  } slmrc_frame_s;

  typedef logic [CHANS-1:0][SMP_W-1:0] slmrc_chan_t;
endpackage

// *** hdl/slmrc_skid_buf.sv ***
// two-entry frame buffer with valid and ready on both sides
`timescale 1ns/100ps
module slmrc_skid_buf
  import slmrc_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         srst,
  input  wire logic         clkEn,
  input  wire logic         flush,
  input  slmrc_pkg::slmrc_frame_s inData,
  input  wire logic         inValid,
  output logic              inReady,
  output slmrc_pkg::slmrc_frame_s outData,
  output logic              outValid,
  input  wire logic         outReady
);
  import slmrc_pkg::*;

  slmrc_frame_s skidData;
  logic         skidValid;

  // second entry catches the word taken while the output stalls
  assign inReady = !skidValid;

  // output entry reloads from the skid entry first to keep order
  always_ff @(posedge sys_clk)
  begin
    if (srst || (clkEn && flush))
    begin
      outValid  <= 1'b0;
      skidValid <= 1'b0;
      outData   <= '0;
      skidData  <= '0;
    end
    else if (clkEn)
    begin
      if (outReady || !outValid)
      begin
        outValid  <= skidValid || inValid;
        outData   <= skidValid ? skidData : inData;
        skidValid <= 1'b0;
      end
      else if (inValid && inReady)
      begin
        skidData  <= inData;
        skidValid <= 1'b1;
      end
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_stall_holds_word: assert property (clkEn && !flush && outValid && !outReady |=> outValid && $stable(outData))
    else $error("stalled output word changed");
endmodule

// *** verification/slmrc_link_ctrl_tb.sv ***
// self-checking bench for the link control block
`timescale 1ns/100ps
module slmrc_link_ctrl_tb;
  import slmrc_pkg::*;
  logic              sys_clk, srst, clkEn, sysref, linkDownAlarm, timerExpiredAlarm, realignEvent, cgsDone;
  logic              frameInValid, frameInReady, frameOutValid, frameOutReady, syncN, rxEnable, linkResetPulse;
  logic              bufferRelease, lmfcEdge, interpFilterEnable, complexMixEnable, sysrefPeriodCheck, alarmOut;
  logic [3:0]        lag;
  logic [LANES-1:0]  laneWriteStart, activeLaneMask;
  logic [ALM_W-1:0]  systemAlarmFlags, alarmMask;
  slmrc_cfg_s        cfg;
  slmrc_lane_fault_s laneFault;
  slmrc_frame_s      frameIn, frameOut;
  slmrc_chan_t       ducOut, ncoTone, toneLevel;
  slmrc_param_s      linkParams;
  logic signed [17:0] convSample;
  int                fails, compares, n;

  slmrc_link_ctrl slmrc_link_ctrl_i (.*);
  slmrc_tx_model slmrc_tx_model_i (.*);

  // free-running clock, 8 ns period
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask

  task automatic close_out();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chkf(input string nm, input slmrc_frame_s e, input slmrc_frame_s g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // bounded wait; a hang ends the run through the closing report
  task automatic waitv(input int w, input string nm);
    int k;
    k = 0;
    while ((w == 0 ? bufferRelease : frameOutValid) !== 1'b1 && k < 300)
    begin
      cyc(1);
      k++;
    end
    if (k == 300)
    begin
      fails++;
      $display("MISMATCH wait %s expected 1 seen 0", nm);
      close_out();
    end
  endtask

  // sample k sits in slot k, or for step 2 in slot k/2 (even) or 8+k/2 (odd)
  function automatic slmrc_frame_s expf(input int sq, input int st);
    slmrc_frame_s f;
    for (int k = 0; k < SLOTS; k++)
      f.smp[k] = {sq[7:0], 8'(st == 2 ? (k % 2) * 8 + k / 2 : k)};
    return f;
  endfunction

  task automatic drain(input int sq, input int st);
    waitv(1, "frameOutValid");
    chkf("frameOut", expf(sq, st), frameOut);
    frameOutReady = 1'b1;
    cyc(1);
    frameOutReady = 1'b0;
    cyc(1);
  endtask

  // one-cycle cause, then pulse and renewed sync request
  task automatic fault(input int c, input logic e);
    case (c)
      0: laneFault.gearboxFault[15] = 1'b1;
      1: laneFault.gearboxFault[0] = 1'b1;
      2: laneFault.bufferOverflowError[3] = 1'b1;
      3: linkDownAlarm = 1'b1;
      4: timerExpiredAlarm = 1'b1;
      default: realignEvent = 1'b1;
    endcase
    cyc(1);
    {laneFault, linkDownAlarm, timerExpiredAlarm, realignEvent} = '0;
    chk("linkResetPulse", e, linkResetPulse);
    cyc(1);
    chk("syncN", !e, syncN);
    if (e)
      waitv(0, "bufferRelease");
  endtask

  initial
  begin
    fails = 0;
    compares = 0;
    cfg = '0;
    cfg.subclassZero = 1'b1;
    cfg.interpolationFactor = 9'h001;
    cfg.sampleInterleaveStep = 5'h01;
    cfg.framesPerMultiframeMinusOne = 8'h1F;
    {laneFault, linkDownAlarm, timerExpiredAlarm, realignEvent, sysref, frameOutReady} = '0;
    {systemAlarmFlags, alarmMask, ducOut, ncoTone, toneLevel, lag} = '0;
    clkEn = 1'b1;
    srst = 1'b1;
    cyc(4);
    chk("syncN", 1, syncN);
    chk("rxEnable", 0, rxEnable);
    srst = 1'b0;
    waitv(0, "bufferRelease");
    cyc(6);
    chk("rxEnable", 1, rxEnable);
    chk("frameInReady", 0, frameInReady);
    drain(0, 1);
    drain(1, 1);
    n = 0;
    // SYSREF held high must not disturb the free-running subclass 0 counter
    sysref = 1'b1;
    repeat (128)
    begin
      cyc(1);
      n += lmfcEdge;
    end
    sysref = 1'b0;
    chk("lmfcEdges", 2, n);
    $display("test link_up done");
    // per-mode table with stream count left at the maximum
    for (int m = 0; m < 3; m++)
    begin
      cfg.linkModeNumber = 5'(m);
      cyc(2);
      chk("lanesPerStream", 16 >> m, linkParams.lanesPerStream);
      chk("maxStreamCount", 1 << m, linkParams.maxStreamCount);
      chk("maxLaneCount", 16, linkParams.maxLaneCount);
      chk("activeLanes", 16, linkParams.activeLanes);
    end
    cfg.streamCount = 8'h01;
    lag = 4'h3;
    cyc(2);
    chk("activeLaneMask", 16'h000F, activeLaneMask);
    for (int c = 0; c < 6; c++)
      fault(c, c != 0);
    cfg.linkModeNumber = 5'h00;
    cfg.streamCount = 8'h00;
    cfg.sampleInterleaveStep = 5'h02;
    cyc(1);
    fault(5, 1);
    cyc(6);
    drain(0, 2);
    $display("test link_reset done");
    cfg.framesPerMultiframeMinusOne = 8'h0F;
    cyc(2);
    chk("multiframeLegal", 0, linkParams.multiframeLegal);
    cfg.framesPerMultiframeMinusOne = 8'h10;
    cyc(2);
    chk("multiframeLegal", 0, linkParams.multiframeLegal);
    cfg.framesPerMultiframeMinusOne = 8'h1F;
    cyc(2);
    chk("multiframeLegal", 1, linkParams.multiframeLegal);
    systemAlarmFlags = 8'hA5;
    alarmMask = 8'h0F;
    cyc(2);
    chk("alarmOut", 1, alarmOut);
    alarmMask = 8'hA5;
    cyc(2);
    chk("alarmOut", 0, alarmOut);
    // frozen clock enable holds the pin until it runs again
    clkEn = 1'b0;
    alarmMask = 8'h0F;
    cyc(2);
    chk("alarmOut", 0, alarmOut);
    clkEn = 1'b1;
    cyc(1);
    chk("alarmOut", 1, alarmOut);
    ducOut = {4{16'h7FFF}};
    cyc(2);
    chk("convSample", 18'h1FFFC, convSample);
    ncoTone = {4{16'h4000}};
    toneLevel = {16'hFFFF, 16'h0000, 16'h4000, 16'h8000};
    cfg.ddsMode = 1'b1;
    cfg.linkModeNumber = 5'h1F;
    cyc(3);
    chk("convSample", 18'h06FFF, convSample);
    chk("interpFilterEnable", 0, interpFilterEnable);
    chk("complexMixEnable", 0, complexMixEnable);
    chk("rxEnable", 0, rxEnable);
    chk("syncN", 1, syncN);
    chk("sysrefPeriodCheck", 0, sysrefPeriodCheck);
    chk("ratioX2", 2, linkParams.ratioX2);
    cfg.ddsMode = 1'b0;
    cyc(2);
    chk("modeInvalid", 1, linkParams.modeInvalid);
    chk("activeLaneMask", 0, activeLaneMask);
    cfg.linkModeNumber = 5'h00;
    cfg.dualEdge1x = 1'b1;
    cyc(2);
    chk("ratioX2", 1, linkParams.ratioX2);
    chk("samplesPerClock", 2, linkParams.samplesPerClock);
    cfg.dualEdge1x = 1'b0;
    cfg.dualEdge2x = 1'b1;
    cfg.interpolationFactor = 9'h100;
    cyc(2);
    chk("ratioX2", 10'h200, linkParams.ratioX2);
    cfg.interpolationFactor = 9'h008;
    cyc(2);
    chk("ratioX2", 10'h010, linkParams.ratioX2);
    $display("test modes done");
    close_out();
  end
endmodule

// *** verification/slmrc_tx_model.sv ***
// transmitter stand-in for the far end of the serial link
`timescale 1ns/100ps
module slmrc_tx_model
  import slmrc_pkg::*;
(
  input  wire logic                        sys_clk,
  input  wire logic                        srst,
  input  wire logic                        syncN,
  input  wire logic [3:0]                  lag,
  input  wire logic [slmrc_pkg::LANES-1:0] activeLaneMask,
  input  wire logic                        frameInReady,
  output logic                             cgsDone,
  output logic [slmrc_pkg::LANES-1:0]      laneWriteStart,
  output slmrc_pkg::slmrc_frame_s          frameIn,
  output logic                             frameInValid
);
  logic [3:0] waitCnt;
  logic [7:0] seqNo;
  logic       took;
  // quiet outputs before the first falling edge
  initial
  begin
    {waitCnt, cgsDone, laneWriteStart, frameInValid, took} = '0;
    frameIn = '1;
  end
  // note the words the receiver took at its sampling edge
  always @(posedge sys_clk)
    took <= frameInValid && frameInReady;
  // moves only at the falling edge so the receiver never races it
  always @(negedge sys_clk)
  begin
    if (srst || !syncN)
    begin
      cgsDone = !srst && waitCnt >= lag;
      waitCnt = srst ? 4'h0 : waitCnt + {3'h0, !cgsDone};
      seqNo = 8'h00;
      frameInValid = 1'b0;
      laneWriteStart = '0;
    end
    else
    begin
      waitCnt = 4'h0;
      laneWriteStart = activeLaneMask;
      seqNo = seqNo + {7'h0, took};
      frameInValid = 1'b1;
    end
    // idle data is inverted so stale words never look valid
    for (int p = 0; p < SLOTS; p++)
      frameIn.smp[p] = {seqNo, 8'(p)} ^ {SMP_W{!frameInValid}};
  end
endmodule
